// [src/pvs_pkg.sv]
// Constants for the output voltage, output current and input status registers
`default_nettype none
package pvs_pkg;
    // Command codes
    localparam logic [7:0] CMD_CLEAR_FAULTS        = 8'h03;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STAT = 8'h7A;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_STAT = 8'h7B;
    localparam logic [7:0] CMD_INPUT_SUPPLY_STAT   = 8'h7C;

    // Output voltage status fields
    localparam int VOUT_OV_FAULT_BIT = 7;
    localparam int VOUT_OV_WARN_BIT  = 6;
    localparam int VOUT_UV_WARN_BIT  = 5;
    localparam int VOUT_UV_FAULT_BIT = 4;
    localparam int VOUT_LIMIT_BIT    = 3;
    localparam int VOUT_TON_BIT      = 2;
    localparam logic [7:0] VOUT_LATCH_MASK = 8'hFC;

    // Output current status fields
    localparam int IOUT_OC_FAULT_BIT = 7;
    localparam int IOUT_OC_WARN_BIT  = 5;
    localparam logic [7:0] IOUT_LATCH_MASK = 8'hA0;

    // Input supply status fields
    localparam int INPUT_OVF_BIT   = 7;
    localparam int INPUT_UVW_BIT   = 5;
    localparam int INPUT_LOW_BIT   = 3;
    localparam logic [7:0] INPUT_LATCH_MASK = 8'hA0;

    // Extended mask fields for the overvoltage fault sources
    localparam int EXT_OVP_FIXED_BIT    = 0;
    localparam int EXT_OVP_TRACKING_BIT = 1;
    localparam int EXT_OVP_PREBIAS_BIT  = 2;

    // Reset values
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [2:0] OVF_SRC_RESET    = 3'h0;
    localparam logic       INPUT_LOW_RESET  = 1'b1;

    // Link side handshake states
    typedef enum logic [0:0] {
        LINK_IDLE,
        LINK_WAIT
    } pvs_link_state_t;
endpackage : pvs_pkg
`default_nettype wire

// [src/pvs_toggle_sync.sv]
// Toggle to pulse crossing into a destination clock domain
`default_nettype none
module pvs_toggle_sync (
    // Destination clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Toggle from the source domain
    input  wire logic src_toggle,
    // One-cycle pulse per toggle
    output logic      pulse
);
    logic meta;
    logic sync;
    logic last;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= src_toggle;
            sync <= meta;
            last <= sync;
        end
    end

    assign pulse = sync ^ last;
endmodule : pvs_toggle_sync
`default_nettype wire

// [src/pvs_status_regs.sv]
// Output voltage, output current and input supply status registers
`default_nettype none
module pvs_status_regs
    import pvs_pkg::*;
(
    // Core clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Link clock
    input  wire logic       link_clk,
    // Link command
    input  wire logic       cmd_valid,
    input  wire logic       cmd_write,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_wdata,
    output logic            cmd_busy,
    // Link response
    output logic            rsp_valid,
    output logic [7:0]      rsp_rdata,
    output logic            rsp_error,
    // Output voltage conditions
    input  wire logic       out_overvolt_fixed,
    input  wire logic       out_overvolt_tracking,
    input  wire logic       out_overvolt_prebias,
    input  wire logic       out_overvolt_warn_fixed,
    input  wire logic       out_overvolt_warn_tracking,
    input  wire logic       out_undervolt_warn,
    input  wire logic       out_undervolt_fault,
    input  wire logic       out_setpoint_limit_event,
    input  wire logic       turn_on_timeout,
    // Output current conditions
    input  wire logic       out_overcurrent_fault,
    input  wire logic       out_overcurrent_warn,
    // Input supply conditions
    input  wire logic       in_overvolt_fault,
    input  wire logic       in_undervolt_warn,
    input  wire logic       power_input_above_turn_on,
    input  wire logic       power_input_above_turn_off,
    input  wire logic       internal_bias_rail_ok,
    // Alert masks
    input  wire logic [7:0] alert_mask_vout,
    input  wire logic [7:0] alert_mask_iout,
    input  wire logic [7:0] alert_mask_input,
    input  wire logic [2:0] alert_mask_ext_reg,
    // Alert and summary
    output logic            alert_request,
    output logic            summary_vout,
    output logic            summary_iout,
    output logic            summary_input
);

    // Set wins over clear, so an event in the clearing cycle survives
    function automatic logic [7:0] latch_bits(input logic [7:0] cur,
                                              input logic [7:0] set,
                                              input logic [7:0] clr,
                                              input logic [7:0] keep);
        latch_bits = ((cur & ~clr) | set) & keep;
    endfunction : latch_bits

    // ---------------- Link domain ----------------
    logic            link_rst_meta;
    logic            link_rst;
    pvs_link_state_t link_state;
    logic            link_req;
    logic            link_write;
    logic [7:0]      link_code;
    logic [7:0]      link_wdata;
    logic            link_ack_pulse;

    // Core reset carried over so the link side starts cleanly
    always_ff @(posedge link_clk) begin
        link_rst_meta <= rst;
        link_rst      <= link_rst_meta;
    end

    wire link_take = (link_state == LINK_IDLE) && cmd_valid;

    // Command words stay frozen while the core works on them
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            link_state <= LINK_IDLE;
            link_req   <= 1'b0;
            link_write <= 1'b0;
            link_code  <= 8'h00;
            link_wdata <= 8'h00;
        end else begin
            case (link_state)
                LINK_IDLE: begin
                    if (link_take) begin
                        link_write <= cmd_write;
                        link_code  <= cmd_code;
                        link_wdata <= cmd_wdata;
                        link_req   <= ~link_req;
                        link_state <= LINK_WAIT;
                    end
                end
                LINK_WAIT: begin
                    if (link_ack_pulse) begin
                        link_state <= LINK_IDLE;
                    end
                end
                default: begin
                    link_state <= LINK_IDLE;
                end
            endcase
        end
    end

    logic [7:0] core_rdata;
    logic       core_error;
    logic       core_ack;

    // Response words are stable in the core until the next request
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            cmd_busy  <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            rsp_error <= 1'b0;
        end else begin
            rsp_valid <= link_ack_pulse && (link_state == LINK_WAIT);
            if (link_take) begin
                cmd_busy <= 1'b1;
            end else if (link_ack_pulse) begin
                cmd_busy <= 1'b0;
            end
            if (link_ack_pulse) begin
                rsp_rdata <= core_rdata;
                rsp_error <= core_error;
            end
        end
    end

    pvs_toggle_sync u_ack_sync (
        .clk        (link_clk),
        .rst        (link_rst),
        .src_toggle (core_ack),
        .pulse      (link_ack_pulse)
    );

    // ---------------- Core domain ----------------
    logic req_pulse;

    pvs_toggle_sync u_req_sync (
        .clk        (clk),
        .rst        (rst),
        .src_toggle (link_req),
        .pulse      (req_pulse)
    );

    // Comparator levels are asynchronous to clk
    logic [15:0] cond_meta;
    logic [15:0] cond_sync;
    wire  [15:0] cond_raw = {out_overvolt_fixed, out_overvolt_tracking,
                             out_overvolt_prebias, out_overvolt_warn_fixed,
                             out_overvolt_warn_tracking, out_undervolt_warn,
                             out_undervolt_fault, out_setpoint_limit_event,
                             turn_on_timeout, out_overcurrent_fault,
                             out_overcurrent_warn, in_overvolt_fault,
                             in_undervolt_warn, power_input_above_turn_on,
                             power_input_above_turn_off, internal_bias_rail_ok};

    always_ff @(posedge clk) begin
        if (rst) begin
            cond_meta <= 16'h0000;
            cond_sync <= 16'h0000;
        end else begin
            cond_meta <= cond_raw;
            cond_sync <= cond_meta;
        end
    end

    wire s_ovp_fixed;
    wire s_ovp_tracking;
    wire s_ovp_prebias;
    wire s_ovw_fixed;
    wire s_ovw_tracking;
    wire s_out_uvw;
    wire s_out_uvf;
    wire s_limit;
    wire s_ton;
    wire s_ocf;
    wire s_ocw;
    wire s_in_ovf;
    wire s_in_uvw;
    wire s_above_on;
    wire s_above_off;
    wire s_bias_ok;
    assign {s_ovp_fixed, s_ovp_tracking, s_ovp_prebias, s_ovw_fixed, s_ovw_tracking,
            s_out_uvw, s_out_uvf, s_limit, s_ton, s_ocf, s_ocw, s_in_ovf, s_in_uvw,
            s_above_on, s_above_off, s_bias_ok} = cond_sync;

    // Command decode; link words are held stable across the handshake
    wire is_clear = (link_code == CMD_CLEAR_FAULTS);
    wire is_vout  = (link_code == CMD_OUTPUT_VOLTAGE_STAT);
    wire is_iout  = (link_code == CMD_OUTPUT_CURRENT_STAT);
    wire is_input = (link_code == CMD_INPUT_SUPPLY_STAT);
    wire clear_all = req_pulse && link_write && is_clear;
    wire wr_vout   = req_pulse && link_write && is_vout;
    wire wr_iout   = req_pulse && link_write && is_iout;
    wire wr_input  = req_pulse && link_write && is_input;
    wire bad_cmd   = !(is_vout || is_iout || is_input || (is_clear && link_write));

    // Write-one-to-clear masks; zeros leave flags alone
    wire [7:0] clr_vout  = clear_all ? 8'hFF : (wr_vout  ? link_wdata : 8'h00);
    wire [7:0] clr_iout  = clear_all ? 8'hFF : (wr_iout  ? link_wdata : 8'h00);
    wire [7:0] clr_input = clear_all ? 8'hFF : (wr_input ? link_wdata : 8'h00);

    logic [7:0] vout_flags;
    logic [7:0] iout_flags;
    logic [7:0] input_flags;
    logic [2:0] ovf_src;
    logic       input_on;
    logic       input_low;
    logic       uvw_armed;

    wire ovf_any = s_ovp_fixed | s_ovp_tracking | s_ovp_prebias;
    wire ovw_any = s_ovw_fixed | s_ovw_tracking;

    wire [7:0] set_vout  = (8'(ovf_any)   << VOUT_OV_FAULT_BIT) |
                           (8'(ovw_any)   << VOUT_OV_WARN_BIT)  |
                           (8'(s_out_uvw) << VOUT_UV_WARN_BIT)  |
                           (8'(s_out_uvf) << VOUT_UV_FAULT_BIT) |
                           (8'(s_limit)   << VOUT_LIMIT_BIT)    |
                           (8'(s_ton)     << VOUT_TON_BIT);
    wire [7:0] set_iout  = (8'(s_ocf) << IOUT_OC_FAULT_BIT) |
                           (8'(s_ocw) << IOUT_OC_WARN_BIT);
    wire [7:0] set_input = (8'(s_in_ovf) << INPUT_OVF_BIT) |
                           (8'(s_in_uvw && uvw_armed) << INPUT_UVW_BIT);

    wire [2:0] ovf_set = {s_ovp_prebias, s_ovp_tracking, s_ovp_fixed};
    wire       ovf_clr = clr_vout[VOUT_OV_FAULT_BIT];

    // Flags hold after the cause ends and re-latch on a new event
    wire [7:0] next_vout_flags  = latch_bits(vout_flags, set_vout, clr_vout,
                                             VOUT_LATCH_MASK);
    wire [7:0] next_iout_flags  = latch_bits(iout_flags, set_iout, clr_iout,
                                             IOUT_LATCH_MASK);
    wire [7:0] next_input_flags = latch_bits(input_flags, set_input, clr_input,
                                             INPUT_LATCH_MASK);
    wire [2:0] next_ovf_src     = (ovf_src & {3{~ovf_clr}}) | ovf_set;

    // Hysteresis between turn-on and turn-off thresholds
    wire next_input_on = s_above_on ? 1'b1 : (s_above_off ? input_on : 1'b0);
    wire next_input_low = !next_input_on || !s_bias_ok;

    always_ff @(posedge clk) begin
        if (rst) begin
            vout_flags  <= STATUS_RESET;
            iout_flags  <= STATUS_RESET;
            input_flags <= STATUS_RESET;
            ovf_src     <= OVF_SRC_RESET;
        end else begin
            vout_flags  <= next_vout_flags;
            iout_flags  <= next_iout_flags;
            input_flags <= next_input_flags;
            ovf_src     <= next_ovf_src;
        end
    end

    // Input reads as off from reset until the rail proves otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            input_on  <= 1'b0;
            input_low <= INPUT_LOW_RESET;
            uvw_armed <= 1'b0;
        end else begin
            input_on  <= next_input_on;
            input_low <= next_input_low;
            if (s_above_on) begin
                uvw_armed <= 1'b1;
            end
        end
    end

    // Readback; unsupported bits are forced to zero by the latch masks
    wire [7:0] input_byte = input_flags | (8'(input_low) << INPUT_LOW_BIT);
    wire [7:0] read_byte  = is_vout ? vout_flags :
                            is_iout ? iout_flags :
                            is_input ? input_byte : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            core_rdata <= 8'h00;
            core_error <= 1'b0;
            core_ack   <= 1'b0;
        end else if (req_pulse) begin
            core_rdata <= link_write ? 8'h00 : read_byte;
            core_error <= bad_cmd;
            core_ack   <= ~core_ack;
        end
    end

    // Alert: each group masked bit by bit, the low-input bit left out
    wire [2:0] ovf_src_open = ovf_src & ~alert_mask_ext_reg;
    wire ovf_alert = vout_flags[VOUT_OV_FAULT_BIT] && !alert_mask_vout[VOUT_OV_FAULT_BIT]
                     && (|ovf_src_open);
    wire [7:0] vout_open  = vout_flags & ~alert_mask_vout &
                            ~(8'h01 << VOUT_OV_FAULT_BIT);
    wire [7:0] iout_open  = iout_flags & ~alert_mask_iout;
    wire [7:0] input_open = input_flags & ~alert_mask_input;
    wire next_alert = ovf_alert || (|vout_open) || (|iout_open) || (|input_open);

    always_ff @(posedge clk) begin
        if (rst) begin
            alert_request <= 1'b0;
            summary_vout  <= 1'b0;
            summary_iout  <= 1'b0;
            summary_input <= INPUT_LOW_RESET;
        end else begin
            alert_request <= next_alert;
            summary_vout  <= |next_vout_flags;
            summary_iout  <= |next_iout_flags;
            summary_input <= (|next_input_flags) || next_input_low;
        end
    end
endmodule : pvs_status_regs
`default_nettype wire

// [tb/pvs_status_regs_properties.sv]
// Port assertions for the status register block
`default_nettype none
module pvs_status_regs_properties (
    // Clocks and reset
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       link_clk,
    // Link side
    input wire logic       cmd_valid,
    input wire logic       cmd_busy,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_rdata,
    // Status side
    input wire logic       out_overcurrent_fault,
    input wire logic       internal_bias_rail_ok,
    input wire logic [7:0] alert_mask_vout,
    input wire logic [7:0] alert_mask_iout,
    input wire logic [7:0] alert_mask_input,
    input wire logic       alert_request,
    input wire logic       summary_iout,
    input wire logic       summary_input
);
    sequence s_take;
        cmd_valid && !cmd_busy;
    endsequence
    sequence s_all_masked;
        (&alert_mask_vout) && (&alert_mask_iout) && (&alert_mask_input);
    endsequence

    // Conditions pass a two-flop synchroniser, hence the slack
    a_summary_current: assert property (@(posedge clk) disable iff (rst)
        out_overcurrent_fault [*4] |-> ##[1:4] summary_iout) else $error("current summary late");
    a_bias_input_low: assert property (@(posedge clk) disable iff (rst)
        !internal_bias_rail_ok [*4] |-> ##[1:4] summary_input) else $error("input low missed");
    a_masked_quiet: assert property (@(posedge clk) disable iff (rst)
        s_all_masked [*3] |-> !alert_request) else $error("alert despite masks");
    a_take_busy: assert property (@(posedge link_clk) disable iff (rst)
        s_take |=> cmd_busy) else $error("busy not raised");
    a_take_answer: assert property (@(posedge link_clk) disable iff (rst)
        s_take |-> ##[1:16] rsp_valid) else $error("no response");
    a_rsp_pulse: assert property (@(posedge link_clk) disable iff (rst)
        rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
    a_busy_fall: assert property (@(posedge link_clk) disable iff (rst)
        $fell(cmd_busy) |-> rsp_valid) else $error("busy fell without response");
    a_rdata_hold: assert property (@(posedge link_clk) disable iff (rst)
        !rsp_valid |-> $stable(rsp_rdata)) else $error("read data moved");
endmodule : pvs_status_regs_properties

bind pvs_status_regs pvs_status_regs_properties i_props (
    .clk(clk), .rst(rst), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_busy(cmd_busy),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .out_overcurrent_fault(out_overcurrent_fault),
    .internal_bias_rail_ok(internal_bias_rail_ok), .alert_mask_vout(alert_mask_vout),
    .alert_mask_iout(alert_mask_iout), .alert_mask_input(alert_mask_input),
    .alert_request(alert_request), .summary_iout(summary_iout), .summary_input(summary_input)
);
`default_nettype wire

// [tb/pvs_host_model.sv]
// Behavioural host on the link command port
`default_nettype none
module pvs_host_model (
    // Link clock
    input  wire logic       link_clk,
    // Command
    output logic            cmd_valid,
    output logic            cmd_write,
    output logic [7:0]      cmd_code,
    output logic [7:0]      cmd_wdata,
    // Response
    input  wire logic       cmd_busy,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_rdata,
    input  wire logic       rsp_error
);
    initial begin
        cmd_valid = 1'h0;
        cmd_write = 1'h0;
        cmd_code  = 8'h00;
        cmd_wdata = 8'h00;
    end

    // Valid drops once busy shows the take; held longer it would be taken twice
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic err);
        int n;
        n = 0;
        @(posedge link_clk);
        cmd_valid <= 1'h1;
        cmd_write <= wr;
        cmd_code  <= code;
        cmd_wdata <= wdata;
        do begin
            @(posedge link_clk);
            n++;
        end while (cmd_busy !== 1'h1 && n < 40);
        cmd_valid <= 1'h0;
        cmd_code  <= ~code;
        cmd_wdata <= ~wdata;
        while (rsp_valid !== 1'h1 && n < 80) begin
            @(posedge link_clk);
            n++;
        end
        rdata = rsp_rdata;
        err   = rsp_error;
    endtask : xfer
endmodule : pvs_host_model
`default_nettype wire

// [tb/test_pvs_status_regs.sv]
// Self-checking bench for the status register block
`default_nettype none
module test_pvs_status_regs
    import pvs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [12:0] cond;
        logic [7:0]  code;
        logic [7:0]  exp;
        logic [7:0]  mask;
        logic [2:0]  ext;
        logic        alert;
    } pvs_row_t;

    logic        clk = 1'h0;
    logic        link_clk = 1'h0;
    logic        rst = 1'h1;
    logic [12:0] cond = 13'h0000;
    logic        above_on = 1'h0;
    logic        above_off = 1'h0;
    logic        bias_ok = 1'h1;
    logic [7:0]  mask = 8'h00;
    logic [2:0]  ext = 3'h0;
    logic        cmd_valid, cmd_write, cmd_busy, rsp_valid, rsp_error;
    logic [7:0]  cmd_code, cmd_wdata, rsp_rdata;
    logic        alert_request, summary_vout, summary_iout, summary_input;
    logic [3:0]  side;
    int          errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    pvs_row_t    rows [16] = '{
        '{13'h0001, 8'h7A, 8'h80, 8'h00, 3'h0, 1'h1}, '{13'h0002, 8'h7A, 8'h80, 8'h80, 3'h0, 1'h0},
        '{13'h0004, 8'h7A, 8'h80, 8'h00, 3'h3, 1'h1}, '{13'h0001, 8'h7A, 8'h80, 8'h00, 3'h1, 1'h0},
        '{13'h0008, 8'h7A, 8'h40, 8'h00, 3'h0, 1'h1}, '{13'h0010, 8'h7A, 8'h40, 8'h40, 3'h0, 1'h0},
        '{13'h0020, 8'h7A, 8'h20, 8'h00, 3'h0, 1'h1}, '{13'h0040, 8'h7A, 8'h10, 8'h00, 3'h0, 1'h1},
        '{13'h0080, 8'h7A, 8'h08, 8'h00, 3'h0, 1'h1}, '{13'h0100, 8'h7A, 8'h04, 8'hFF, 3'h0, 1'h0},
        '{13'h0200, 8'h7B, 8'h80, 8'h00, 3'h0, 1'h1}, '{13'h0400, 8'h7B, 8'h20, 8'h80, 3'h0, 1'h1},
        '{13'h0800, 8'h7C, 8'h80, 8'h00, 3'h0, 1'h1}, '{13'h1000, 8'h7C, 8'h20, 8'h20, 3'h0, 1'h0},
        '{13'h0004, 8'h7A, 8'h80, 8'h00, 3'h4, 1'h0}, '{13'h0002, 8'h7A, 8'h80, 8'h00, 3'h2, 1'h0}};

    assign side = {summary_vout, summary_iout, summary_input, alert_request};
    always #5 clk = ~clk;
    always #32 link_clk = ~link_clk;

    pvs_status_regs i_dut (
        .clk(clk), .rst(rst), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .out_overvolt_fixed(cond[0]),
        .out_overvolt_tracking(cond[1]), .out_overvolt_prebias(cond[2]),
        .out_overvolt_warn_fixed(cond[3]), .out_overvolt_warn_tracking(cond[4]),
        .out_undervolt_warn(cond[5]), .out_undervolt_fault(cond[6]),
        .out_setpoint_limit_event(cond[7]), .turn_on_timeout(cond[8]),
        .out_overcurrent_fault(cond[9]), .out_overcurrent_warn(cond[10]),
        .in_overvolt_fault(cond[11]), .in_undervolt_warn(cond[12]),
        .power_input_above_turn_on(above_on), .power_input_above_turn_off(above_off),
        .internal_bias_rail_ok(bias_ok), .alert_mask_vout(mask), .alert_mask_iout(mask),
        .alert_mask_input(mask), .alert_mask_ext_reg(ext), .alert_request(alert_request),
        .summary_vout(summary_vout), .summary_iout(summary_iout), .summary_input(summary_input));

    pvs_host_model i_host (
        .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_error(rsp_error));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        logic [7:0] d;
        logic       e;
        i_host.xfer(1'h0, code, 8'h00, d, e);
        check(d, exp);
        check({7'h00, e}, 8'h00);
    endtask : rd

    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        logic [7:0] d;
        logic       e;
        i_host.xfer(1'h1, code, data, d, e);
        check({7'h00, e}, 8'h00);
    endtask : wr

    task automatic pulse(input logic [12:0] c);
        cond <= c;
        repeat (8) @(posedge clk);
        cond <= 13'h0000;
        repeat (8) @(posedge clk);
    endtask : pulse

    task automatic summarize();
        $display("Mismatches %0d, comparisons %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // Generous ceiling; a normal run needs well under a tenth of it
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        logic [7:0] d;
        logic       e;
        logic [3:0] want;
        // Held past three link edges so the link side resets as well
        repeat (40) @(posedge clk);
        rst <= 1'h0;
        repeat (40) @(posedge clk);
        check({4'h0, side}, 8'h02);
        rd(CMD_OUTPUT_VOLTAGE_STAT, 8'h00);
        rd(CMD_OUTPUT_CURRENT_STAT, 8'h00);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h08);
        pulse(13'h1000);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h08);
        above_on <= 1'h1;
        above_off <= 1'h1;
        pulse(13'h0000);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h00);
        bias_ok <= 1'h0;
        pulse(13'h0000);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h08);
        check({4'h0, side}, 8'h02);
        bias_ok <= 1'h1;
        pulse(13'h0000);
        check({4'h0, side}, 8'h00);
        // Between thresholds the input keeps its last state
        @(posedge clk);
        above_on <= 1'h0;
        pulse(13'h0000);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h00);
        @(posedge clk);
        above_off <= 1'h0;
        pulse(13'h0000);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h08);
        @(posedge clk);
        above_on <= 1'h1;
        above_off <= 1'h1;
        pulse(13'h0000);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h00);
        foreach (rows[i]) begin
            @(posedge clk);
            mask <= rows[i].mask;
            ext <= rows[i].ext;
            pulse(rows[i].cond);
            want = {rows[i].code == CMD_OUTPUT_VOLTAGE_STAT,
                    rows[i].code == CMD_OUTPUT_CURRENT_STAT,
                    rows[i].code == CMD_INPUT_SUPPLY_STAT, rows[i].alert};
            check({4'h0, side}, {4'h0, want});
            rd(rows[i].code, rows[i].exp);
            wr(rows[i].code, 8'h00);
            rd(rows[i].code, rows[i].exp);
            wr(rows[i].code, 8'hFF);
            rd(rows[i].code, 8'h00);
            check({4'h0, side}, 8'h00);
        end
        mask <= 8'h00;
        ext <= 3'h0;
        // Clear while the cause persists: the flag must survive
        cond <= 13'h0200;
        repeat (8) @(posedge clk);
        wr(CMD_OUTPUT_CURRENT_STAT, 8'h80);
        rd(CMD_OUTPUT_CURRENT_STAT, 8'h80);
        pulse(13'h1FFF);
        wr(CMD_CLEAR_FAULTS, 8'h00);
        rd(CMD_OUTPUT_VOLTAGE_STAT, 8'h00);
        rd(CMD_OUTPUT_CURRENT_STAT, 8'h00);
        rd(CMD_INPUT_SUPPLY_STAT, 8'h00);
        check({4'h0, side}, 8'h00);
        i_host.xfer(1'h0, 8'h7D, 8'h00, d, e);
        check({7'h00, e}, 8'h01);
        check(d, 8'h00);
        summarize();
    end
endmodule : test_pvs_status_regs
`default_nettype wire
